// >>> rgmii_skew_pkg.sv
`default_nettype none
package rgmii_skew_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int THR_W = 3;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h32;
    localparam logic [7:0] IDX_CTRL2 = 8'h33;
    localparam logic [7:0] IDX_STATUS = 8'h34;
    localparam logic [7:0] IDX_RX_MODE = 8'h60;
    localparam logic [15:0] CTRL_RESET = 16'h00d0;
    localparam logic [15:0] CTRL_WMASK = 16'h00ff;
    localparam logic [15:0] CTRL2_WMASK = 16'h0006;
    localparam logic [15:0] RX_MODE_WMASK = 16'h0010;
    // Field positions
    localparam int RX_CLK_DLY_BIT = 0;
    localparam int TX_CLK_DLY_BIT = 1;
    localparam int TX_ERR_SUP_BIT = 2;
    localparam int TX_THR_LSB = 3;
    localparam int RX_THR_LSB = 5;
    localparam int TX_THR_MSB_BIT = 2;
    localparam int RX_THR_MSB_BIT = 1;
    localparam int RX_MODE_BIT = 4;
    localparam int STAT_RX_LVL_LSB = 8;
    // Receive mode floor when not in recovered-clock mode
    localparam logic [2:0] LOCAL_MODE_MIN_THR = 3'h2;
    // Receive link clock generation
    localparam int CLK_NS = 10;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_PERIOD_CYC = LINK_PERIOD_NS / CLK_NS;
    localparam int LINK_HALF_CYC = LINK_PERIOD_CYC / 2;
    localparam int LINK_SHIFT_CYC = LINK_PERIOD_CYC / 4;
endpackage : rgmii_skew_pkg
`default_nettype wire

// >>> sync_fifo_if.sv
`default_nettype none
interface sync_fifo_if #(parameter int WIDTH = 9, parameter int LVL_W = 4);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic full;
    logic pop;
    logic [WIDTH-1:0] pop_data;
    logic pop_valid;
    logic [LVL_W-1:0] level;
    logic [2:0] threshold;
    logic armed;
    modport ctl (output push, push_data, pop, threshold,
                 input full, pop_data, pop_valid, level, armed);
    modport fifo (input push, push_data, pop, threshold,
                  output full, pop_data, pop_valid, level, armed);
endinterface : sync_fifo_if
`default_nettype wire

// >>> sync_fifo.sv
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8,
    parameter int LVL_W = 4
) (
    input wire logic clk,
    input wire logic rstn,
    sync_fifo_if.fifo f
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [LVL_W-1:0] level_ff;
    logic armed_ff;
    logic [WIDTH-1:0] rd_data_ff;
    logic rd_valid_ff;
    logic do_push;
    logic do_pop;
    logic [LVL_W-1:0] nxt_level;
    logic [2:0] eff_thr;

    assign do_push = f.push && (level_ff != LVL_W'(DEPTH));
    assign do_pop = f.pop && armed_ff && (level_ff != '0);
    assign eff_thr = (f.threshold == '0) ? 3'h1 : f.threshold;
    assign nxt_level = level_ff + LVL_W'(do_push) - LVL_W'(do_pop);

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= f.push_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            level_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + PTR_W'(do_push);
            rd_ptr_ff <= rd_ptr_ff + PTR_W'(do_pop);
            level_ff <= nxt_level;
        end
    end

    // Drain starts at the threshold and runs until empty
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed_ff <= 1'b0;
        end else if (nxt_level == '0) begin
            armed_ff <= 1'b0;
        end else if (nxt_level >= LVL_W'(eff_thr)) begin
            armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_ff <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= do_pop;
            if (do_pop) begin
                rd_data_ff <= mem_ff[rd_ptr_ff];
            end
        end
    end

    assign f.full = (level_ff == LVL_W'(DEPTH));
    assign f.level = level_ff;
    assign f.armed = armed_ff;
    assign f.pop_data = rd_data_ff;
    assign f.pop_valid = rd_valid_ff;
endmodule : sync_fifo
`default_nettype wire

// >>> rgmii_fifo_clock_skew_control.sv
// Contract
// - Three-bit receive threshold, low bits reset two
// - Receive defaults to recovered-clock mode, selectable
// - Lower receive threshold cuts receive latency, down to two outside recovered-clock mode
// - Three-bit transmit threshold, low bits reset two
// - Transmit clock delay bit selects shifted/aligned
// - Receive clock delay bit selects shifted/aligned
//
// The implementer's own choice: register access over Avalon-MM.
`default_nettype none
module rgmii_fifo_clock_skew_control
    import rgmii_skew_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int LVL_W = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tx_link_clk,
    input wire logic [7:0] tx_link_data,
    input wire logic tx_link_err,
    output logic tx_core_valid,
    output logic [7:0] tx_core_data,
    output logic tx_core_err,
    input wire logic rx_core_valid,
    input wire logic [7:0] rx_core_data,
    output logic rx_link_clk,
    output logic [7:0] rx_link_data,
    output logic rx_recovered_mode
);
    localparam int PH_W = $clog2(LINK_PERIOD_CYC);

    logic [REG_W-1:0] ctrl_ff;
    logic [REG_W-1:0] ctrl2_ff;
    logic [REG_W-1:0] rx_mode_ff;
    logic ack_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [2:0] tx_thr;
    logic [2:0] rx_thr;
    logic [2:0] rx_thr_eff;

    sync_fifo_if #(.WIDTH(9), .LVL_W(LVL_W)) txf ();
    sync_fifo_if #(.WIDTH(8), .LVL_W(LVL_W)) rxf ();

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input logic [DATA_W-1:0] wd,
                                               input logic [3:0] be,
                                               input logic [REG_W-1:0] wmask);
        logic [REG_W-1:0] lane;
        lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
        merge = (old & ~lane) | (wd[REG_W-1:0] & lane);
    endfunction : merge

    // Bus slave, one wait cycle per access
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata = rdata_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RESET;
            ctrl2_ff <= '0;
            rx_mode_ff <= '0;
        end else if (avs_write && !ack_ff) begin
            if (hit(avs_address, IDX_CTRL)) begin
                // Bit seven stays writable; software keeps it set
                ctrl_ff <= merge(ctrl_ff, avs_writedata, avs_byteenable, CTRL_WMASK);
            end
            if (hit(avs_address, IDX_CTRL2)) begin
                ctrl2_ff <= merge(ctrl2_ff, avs_writedata, avs_byteenable, CTRL2_WMASK);
            end
            if (hit(avs_address, IDX_RX_MODE)) begin
                rx_mode_ff <= merge(rx_mode_ff, avs_writedata, avs_byteenable,
                                    RX_MODE_WMASK);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= '0;
        end else if (avs_read && !ack_ff) begin
            if (hit(avs_address, IDX_CTRL)) begin
                rdata_ff <= {16'h0000, ctrl_ff};
            end else if (hit(avs_address, IDX_CTRL2)) begin
                rdata_ff <= {16'h0000, ctrl2_ff};
            end else if (hit(avs_address, IDX_RX_MODE)) begin
                rdata_ff <= {16'h0000, rx_mode_ff};
            end else if (hit(avs_address, IDX_STATUS)) begin
                rdata_ff <= DATA_W'({rxf.level, {(STAT_RX_LVL_LSB - LVL_W){1'b0}}, txf.level});
            end else begin
                rdata_ff <= '0;
            end
        end
    end

    // Threshold assembly
    assign tx_thr = {ctrl2_ff[TX_THR_MSB_BIT], ctrl_ff[TX_THR_LSB +: 2]};
    assign rx_thr = {ctrl2_ff[RX_THR_MSB_BIT], ctrl_ff[RX_THR_LSB +: 2]};
    assign rx_recovered_mode = !rx_mode_ff[RX_MODE_BIT];
    // Low thresholds only take effect in recovered-clock mode
    assign rx_thr_eff = (rx_recovered_mode || rx_thr >= LOCAL_MODE_MIN_THR) ?
                        rx_thr : LOCAL_MODE_MIN_THR;

    // Transmit link sampling
    logic [1:0] tx_clk_sync_ff;
    logic tx_clk_prev_ff;
    logic [8:0] tx_data_sync1_ff;
    logic [8:0] tx_data_sync2_ff;
    logic tx_edge;
    logic tx_edge_dly_ff;
    logic [8:0] tx_data_dly_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_clk_sync_ff <= '0;
            tx_clk_prev_ff <= 1'b0;
            tx_data_sync1_ff <= '0;
            tx_data_sync2_ff <= '0;
            tx_edge_dly_ff <= 1'b0;
            tx_data_dly_ff <= '0;
        end else begin
            tx_clk_sync_ff <= {tx_clk_sync_ff[0], tx_link_clk};
            tx_clk_prev_ff <= tx_clk_sync_ff[1];
            tx_data_sync1_ff <= {tx_link_err, tx_link_data};
            tx_data_sync2_ff <= tx_data_sync1_ff;
            tx_edge_dly_ff <= tx_edge;
            tx_data_dly_ff <= tx_data_sync2_ff;
        end
    end

    assign tx_edge = tx_clk_sync_ff[1] && !tx_clk_prev_ff;

    // Aligned clock and its data are both delayed internally by one cycle before sampling
    assign txf.push = ctrl_ff[TX_CLK_DLY_BIT] ? tx_edge_dly_ff : tx_edge;
    assign txf.push_data = ctrl_ff[TX_CLK_DLY_BIT] ? tx_data_dly_ff : tx_data_sync2_ff;
    assign txf.threshold = tx_thr;
    assign txf.pop = 1'b1;

    sync_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) tx_fifo (
        .clk(clk),
        .rstn(rstn),
        .f(txf)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_core_valid <= 1'b0;
            tx_core_data <= '0;
            tx_core_err <= 1'b0;
        end else begin
            tx_core_valid <= txf.pop_valid;
            if (txf.pop_valid) begin
                tx_core_data <= txf.pop_data[7:0];
                tx_core_err <= txf.pop_data[8] && !ctrl_ff[TX_ERR_SUP_BIT];
            end
        end
    end

    // Receive path toward the link
    logic [PH_W-1:0] phase_ff;
    logic [PH_W-1:0] clk_rise;
    logic nxt_rx_clk;

    assign rxf.push = rx_core_valid;
    assign rxf.push_data = rx_core_data;
    assign rxf.threshold = rx_thr_eff;
    assign rxf.pop = (phase_ff == '0);

    sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) rx_fifo (
        .clk(clk),
        .rstn(rstn),
        .f(rxf)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_ff <= '0;
        end else if (phase_ff == PH_W'(LINK_PERIOD_CYC - 1)) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= phase_ff + 1'b1;
        end
    end

    // Shifted clock rises a quarter period after the data change
    assign clk_rise = ctrl_ff[RX_CLK_DLY_BIT] ? PH_W'(1) :
                      PH_W'(1 + LINK_SHIFT_CYC);
    assign nxt_rx_clk = (phase_ff >= clk_rise) &&
                        ({1'b0, phase_ff} < {1'b0, clk_rise} + (PH_W + 1)'(LINK_HALF_CYC));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_link_clk <= 1'b0;
            rx_link_data <= '0;
        end else begin
            rx_link_clk <= nxt_rx_clk;
            if (rxf.pop_valid) begin
                rx_link_data <= rxf.pop_data;
            end
        end
    end
endmodule : rgmii_fifo_clock_skew_control
`default_nettype wire

// >>> rgmii_mac_model.sv
`default_nettype none
module rgmii_mac_model (
    input wire logic clk,
    output logic link_clk,
    output logic [7:0] link_data,
    output logic link_err
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_clk = 1'b0;
        link_data = 8'h00;
        link_err = 1'b0;
    end
    // One byte per link clock period, clock idle between frames
    task automatic send_frame(input logic [31:0] b, input int n, input logic err_last);
        for (int i = 0; i < n; i++) begin
            link_data <= b[8*i +: 8];
            link_err <= err_last && (i == n - 1);
            repeat (4) @(posedge clk);
            link_clk <= 1'b1;
            repeat (8) @(posedge clk);
            link_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        // Released lines stop showing the last byte
        link_data <= ~link_data;
        link_err <= ~link_err;
    endtask : send_frame
endmodule : rgmii_mac_model
`default_nettype wire

// >>> rgmii_fifo_clock_skew_control_props.sv
`default_nettype none
module rgmii_skew_props
    import rgmii_skew_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic tx_core_valid,
    input wire logic [7:0] tx_core_data,
    input wire logic rx_link_clk,
    input wire logic [7:0] rx_link_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] quiet_ff;
    // Cycles since the last write, rx clock checks pause after one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_ff <= 6'h00;
        end else if (avs_write) begin
            quiet_ff <= 6'h00;
        end else if (quiet_ff != 6'h3f) begin
            quiet_ff <= quiet_ff + 6'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("no wait on first cycle");
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait too long");
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:16] == 16'h0000) else $error("read upper half set");
    a_readdata_stands: assert property ($changed(avs_readdata)
        |-> avs_read && !avs_waitrequest) else $error("read data moved");
    a_rx_clk_period: assert property (disable iff (!rstn || quiet_ff < 6'h14)
        $rose(rx_link_clk) |-> rx_link_clk[*8] ##1 !rx_link_clk) else $error("rx clock period");
    a_rx_data_hold: assert property ($changed(rx_link_data)
        |=> ($stable(rx_link_data))[*8]) else $error("rx data not held");
    a_rx_clk_skew: assert property (disable iff (!rstn || quiet_ff < 6'h14)
        $changed(rx_link_data) |-> $rose(rx_link_clk) or (##4 $rose(rx_link_clk)))
        else $error("rx clock skew");
    a_tx_data_hold: assert property ($changed(tx_core_data)
        |-> tx_core_valid) else $error("tx data moved without valid");
endmodule : rgmii_skew_props
bind rgmii_fifo_clock_skew_control rgmii_skew_props u_rgmii_skew_props (.clk(clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_core_valid(tx_core_valid),
    .tx_core_data(tx_core_data), .rx_link_clk(rx_link_clk), .rx_link_data(rx_link_data));
`default_nettype wire

// >>> tb_rgmii_fifo_clock_skew_control.sv
`default_nettype none
module tb_rgmii_fifo_clock_skew_control import rgmii_skew_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn, avs_read, avs_write, avs_waitrequest, tx_link_clk, tx_link_err;
    logic tx_core_valid, tx_core_err, rx_core_valid, rx_link_clk, rx_recovered_mode;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] tx_link_data, tx_core_data, rx_core_data, rx_link_data;
    logic [8:0] tx_seen [$];
    int bad_count = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    rgmii_mac_model u_rgmii_mac_model (.clk(clk), .link_clk(tx_link_clk), .link_data(tx_link_data),
        .link_err(tx_link_err));
    rgmii_fifo_clock_skew_control u_rgmii_fifo_clock_skew_control (.clk(clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_link_clk(tx_link_clk), .tx_link_data(tx_link_data), .tx_link_err(tx_link_err),
        .tx_core_valid(tx_core_valid), .tx_core_data(tx_core_data), .tx_core_err(tx_core_err),
        .rx_core_valid(rx_core_valid), .rx_core_data(rx_core_data), .rx_link_clk(rx_link_clk),
        .rx_link_data(rx_link_data), .rx_recovered_mode(rx_recovered_mode));
    always @(negedge clk) begin
        if (tx_core_valid === 1'b1) begin
            tx_seen.push_back({tx_core_err, tx_core_data});
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                       input logic [3:0] be, output logic [15:0] rd);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {16'h0000, wd};
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [15:0] exp);
        logic [15:0] v;
        bus(1'b0, idx, 16'h0000, 4'hf, v);
        check(what, {16'h0000, v}, {16'h0000, exp});
    endtask : rd_chk
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] v;
        bus(1'b1, idx, d, 4'h3, v);
    endtask : wr
    task automatic push_rx(input logic [7:0] b);
        rx_core_valid <= 1'b1;
        rx_core_data <= b;
        @(posedge clk);
        rx_core_valid <= 1'b0;
        @(posedge clk);
    endtask : push_rx
    task automatic wait_rx(input logic [7:0] b, output int c);
        c = 0;
        while (rx_link_data !== b && c < 64) begin
            @(negedge clk);
            c++;
        end
        @(posedge clk);
    endtask : wait_rx
    task automatic wait_hi(output int c);
        c = 0;
        while (rx_link_clk !== 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        @(posedge clk);
    endtask : wait_hi
    task automatic t_regs;
        logic [15:0] v;
        rd_chk("ctrl reset", IDX_CTRL, 16'h00d0);
        rd_chk("ctrl2 reset", IDX_CTRL2, 16'h0000);
        rd_chk("mode reset", IDX_RX_MODE, 16'h0000);
        check("recovered", rx_recovered_mode, 1);
        wr(IDX_CTRL, 16'hffa4);
        rd_chk("ctrl", IDX_CTRL, 16'h00a4);
        bus(1'b1, IDX_CTRL, 16'h0000, 4'h2, v);
        rd_chk("ctrl lanes", IDX_CTRL, 16'h00a4);
        wr(IDX_CTRL2, 16'hffff);
        rd_chk("ctrl2", IDX_CTRL2, 16'h0006);
        wr(IDX_RX_MODE, 16'hffff);
        rd_chk("mode", IDX_RX_MODE, 16'h0010);
        check("local mode", rx_recovered_mode, 0);
        wr(8'h10, 16'hffff);
        rd_chk("unmapped", 8'h10, 16'h0000);
        wr(IDX_RX_MODE, 16'h0000);
        wr(IDX_CTRL2, 16'h0000);
        wr(IDX_CTRL, 16'h00d0);
    endtask : t_regs
    task automatic t_rx;
        int c;
        push_rx(8'h5a);
        repeat (48) @(posedge clk);
        check("rx lone byte", rx_link_data, 0);
        rd_chk("rx level", IDX_STATUS, 16'h0100);
        push_rx(8'h6b);
        wait_rx(8'h5a, c);
        check("rx pair", c < 40, 1);
        wait_rx(8'h6b, c);
        wait_hi(c);
        check("rx shifted", c, 4);
        wr(IDX_CTRL, 16'h00b1);
        push_rx(8'hc3);
        wait_rx(8'hc3, c);
        check("rx low thr", c < 40, 1);
        wait_hi(c);
        check("rx aligned", c, 0);
        wr(IDX_RX_MODE, 16'h0010);
        push_rx(8'h7e);
        repeat (48) @(posedge clk);
        check("rx floor", rx_link_data, 8'hc3);
        push_rx(8'h8f);
        wait_rx(8'h8f, c);
        check("rx floor pair", c < 48, 1);
        wr(IDX_RX_MODE, 16'h0000);
    endtask : t_rx
    task automatic t_tx;
        logic [8:0] exp [$];
        wr(IDX_CTRL, 16'h00d8);
        tx_seen.delete();
        u_rgmii_mac_model.send_frame(32'h0000_2211, 2, 1'b0);
        repeat (30) @(posedge clk);
        check("tx held", tx_seen.size(), 0);
        u_rgmii_mac_model.send_frame(32'h0000_0033, 1, 1'b1);
        wr(IDX_CTRL, 16'h00d6);
        u_rgmii_mac_model.send_frame(32'h0000_5544, 2, 1'b1);
        repeat (30) @(posedge clk);
        exp = '{9'h011, 9'h022, 9'h133, 9'h044, 9'h055};
        check("tx count", tx_seen.size(), 5);
        foreach (exp[i]) check("tx byte", tx_seen[i], exp[i]);
    endtask : t_tx
    task automatic final_report;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        #300us;
        bad_count++;
        final_report();
    end
    initial begin
        rstn <= 1'b0;
        avs_address <= '0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= '0;
        avs_byteenable <= 4'h0;
        rx_core_valid <= 1'b0;
        rx_core_data <= 8'h00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_rx();
        t_tx();
        final_report();
    end
endmodule : tb_rgmii_fifo_clock_skew_control
`default_nettype wire
